// ===== shared/vrlc_pkg.sv
// Package: register map, field layout and analog control types of the voltage reference control
package vrlc_pkg;

    // Register byte addresses (chosen, word aligned)
    localparam logic [11:0] ADDR_ENABLE_SOURCE_CTRL = 12'h000;
    localparam logic [11:0] ADDR_LEVEL_CODE         = 12'h004;
    localparam logic [11:0] ADDR_PIN_SENSE          = 12'h008;

    // First control register field positions
    localparam int BIT_CONVERTER_ENABLE     = 7;
    localparam int BIT_PIN1_OUTPUT_ENABLE   = 5;
    localparam int BIT_PIN2_OUTPUT_ENABLE   = 4;
    localparam int BIT_POS_SOURCE_HI        = 3;
    localparam int BIT_POS_SOURCE_LO        = 2;
    localparam int BIT_NEG_SOURCE_SELECT    = 0;

    // Writable masks: unused positions ignore writes and read zero
    localparam logic [7:0] MASK_ENABLE_SOURCE_CTRL = 8'hBD;
    localparam logic [7:0] MASK_LEVEL_CODE         = 8'h1F;

    // Reset values
    localparam logic [7:0] RESET_ENABLE_SOURCE_CTRL = 8'h00;
    localparam logic [7:0] RESET_LEVEL_CODE         = 8'h00;

    // Ladder taps: 32 levels from a 5-bit code
    localparam int LEVEL_BITS  = 5;
    localparam int LEVEL_COUNT = 32;

    // Positive source encodings
    localparam logic [1:0] POS_SOURCE_SUPPLY     = 2'h0;
    localparam logic [1:0] POS_SOURCE_EXT_PIN    = 2'h1;
    localparam logic [1:0] POS_SOURCE_FIXED_REF  = 2'h2;
    localparam logic [1:0] POS_SOURCE_RESERVED   = 2'h3;

    // Analog controls driven to the ladder and pads
    typedef struct packed {
        logic                  ladder_power;      // Ladder biased and active
        logic [LEVEL_COUNT-1:0] tap_select;       // One-hot tap, zero when off
        logic                  pos_supply;        // Top of ladder to supply
        logic                  pos_ext_pin;       // Top of ladder to external pin
        logic                  pos_fixed_ref;     // Top of ladder to fixed reference
        logic                  neg_ext_pin;       // Bottom to external pin, else ground
        logic                  internal_route;    // Feed comparator and ADC channel
    } vrlc_ladder_type;

    typedef struct packed {
        logic analog_connect;     // Level switched onto pin
        logic digital_out_kill;   // Force digital driver off
        logic input_detect_kill;  // Force input threshold detector off
        logic pullup_kill;        // Force weak pull-up off
    } vrlc_pin_ovr_type;

endpackage : vrlc_pkg

// ===== verilog/vrlc_pin_override.sv
// Per-pin override: takes a pad when the reference level is routed onto it
`timescale 1ns/1ns
module vrlc_pin_override (
    input  wire logic                        pclk,        // Register clock
    input  wire logic                        presetn,     // Async reset, active low
    input  wire logic                        route_en,    // Pin selected for reference
    input  wire logic                        pad_in_sync, // Synchronised pad level
    output vrlc_pkg::vrlc_pin_ovr_type       ovr,         // Pad override controls
    output logic                             pin_read     // Digital value seen by reads
);

    vrlc_pkg::vrlc_pin_ovr_type next_ovr;
    logic                       next_pin_read;

    // Override and masked read value follow the route enable together
    always_comb begin
        next_ovr.analog_connect    = route_en;
        next_ovr.digital_out_kill  = route_en;
        next_ovr.input_detect_kill = route_en;
        next_ovr.pullup_kill       = route_en;
        next_pin_read              = route_en ? 1'b0 : pad_in_sync;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovr      <= '0;
            pin_read <= 1'b0;
        end else begin
            ovr      <= next_ovr;
            pin_read <= next_pin_read;
        end
    end

    property p_read_zero;
        @(posedge pclk) disable iff (!presetn)
        route_en |=> !pin_read;
    endproperty
    a_read_zero: assert property (p_read_zero)
        else $error("routed pin read not zero");

    property p_kill_all;
        @(posedge pclk) disable iff (!presetn)
        route_en |=> (ovr.digital_out_kill && ovr.input_detect_kill && ovr.pullup_kill);
    endproperty
    a_kill_all: assert property (p_kill_all)
        else $error("routed pin keeps a digital function");

endmodule : vrlc_pin_override

// ===== verilog/vrlc_top.sv
// Voltage reference level control: APB registers, ladder selects and pin overrides
`timescale 1ns/1ns
// Operation
// - Ladder powered only while enable bit 7 of first register is set
// - Thirty-two levels chosen by five-bit code in second register
// - Output is negative source plus span times code over thirty-two
// - Positive source bits 3:2: supply, external pin, fixed reference; 11 reserved
// - Bit 0 picks ground when clear, external negative pin when set
// - Bit 5 routes level onto first output pin
// - Bit 4 routes level onto second output pin
// - Routed pin loses digital driver, input detector and weak pull-up
// - Digital read of a routed pin returns zero
// - Converter keeps running in sleep; wake leaves first register unchanged
// - Reset disables converter, frees both pins, clears level code
// - Unused bits ignore writes and read zero
// - Level also routed to comparator positive input and ADC channel
module vrlc_top (
    input  wire logic                         pclk,            // 250 MHz register clock
    input  wire logic                         presetn,         // Async reset, active low
    input  wire logic                         psel,            // APB select
    input  wire logic                         penable,         // APB access phase
    input  wire logic                         pwrite,          // APB write
    input  wire logic [11:0]                  paddr,           // APB byte address
    input  wire logic [31:0]                  pwdata,          // APB write data
    input  wire logic [3:0]                   pstrb,           // APB byte strobes
    input  wire logic                         sleep_mode,      // Device in sleep
    input  wire logic                         ref_output_pin1, // Pad 1 level from pin
    input  wire logic                         ref_output_pin2, // Pad 2 level from pin
    output logic [31:0]                       prdata,          // APB read data
    output logic                              pready,          // APB ready
    output logic                              pslverr,         // APB error
    output vrlc_pkg::vrlc_ladder_type         ladder,          // Ladder and source controls
    output vrlc_pkg::vrlc_pin_ovr_type        pin1_ovr,        // Pad 1 overrides
    output vrlc_pkg::vrlc_pin_ovr_type        pin2_ovr         // Pad 2 overrides
);

    // Control registers
    logic [7:0] ref_enable_source_ctrl;
    logic [7:0] ref_level_code;
    logic [7:0] next_ref_enable_source_ctrl;
    logic [7:0] next_ref_level_code;

    // Bus answer state
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;

    // Pad synchronisers
    logic [1:0] pad1_sync;
    logic [1:0] pad2_sync;
    logic       pin1_read;
    logic       pin2_read;

    // Ladder state
    vrlc_pkg::vrlc_ladder_type next_ladder;

    // Decoded fields
    logic                               converter_enable;
    logic                               ref_pin1_output_enable;
    logic                               ref_pin2_output_enable;
    logic [1:0]                         positive_source_select;
    logic                               negative_source_select;
    logic [vrlc_pkg::LEVEL_BITS-1:0]    level_code;

    // Bus phase qualifiers
    logic setup_phase;
    logic write_access;
    logic read_access;
    logic addr_hit;

    // Merge masked write data into a register, honouring the low byte strobe
    function automatic logic [7:0] merge_write(input logic [7:0] cur,
                                               input logic [7:0] wdata,
                                               input logic [7:0] mask,
                                               input logic       strobe);
        logic [7:0] result;
        result = cur;
        if (strobe) begin
            result = wdata & mask;
        end
        return result;
    endfunction : merge_write

    // One-hot ladder tap for a level code
    function automatic logic [vrlc_pkg::LEVEL_COUNT-1:0] tap_decode(
        input logic [vrlc_pkg::LEVEL_BITS-1:0] code);
        logic [vrlc_pkg::LEVEL_COUNT-1:0] onehot;
        onehot = '0;
        onehot[code] = 1'b1;
        return onehot;
    endfunction : tap_decode

    // Field extraction
    assign converter_enable       = ref_enable_source_ctrl[vrlc_pkg::BIT_CONVERTER_ENABLE];
    assign ref_pin1_output_enable = ref_enable_source_ctrl[vrlc_pkg::BIT_PIN1_OUTPUT_ENABLE];
    assign ref_pin2_output_enable = ref_enable_source_ctrl[vrlc_pkg::BIT_PIN2_OUTPUT_ENABLE];
    assign positive_source_select =
        ref_enable_source_ctrl[vrlc_pkg::BIT_POS_SOURCE_HI:vrlc_pkg::BIT_POS_SOURCE_LO];
    assign negative_source_select = ref_enable_source_ctrl[vrlc_pkg::BIT_NEG_SOURCE_SELECT];
    assign level_code             = ref_level_code[vrlc_pkg::LEVEL_BITS-1:0];

    // Bus phases: answer is registered from setup, so access phase completes with no wait state
    assign setup_phase  = psel && !penable;
    assign addr_hit     = (paddr == vrlc_pkg::ADDR_ENABLE_SOURCE_CTRL) ||
                          (paddr == vrlc_pkg::ADDR_LEVEL_CODE) ||
                          (paddr == vrlc_pkg::ADDR_PIN_SENSE);
    assign write_access = psel && penable && pready && pwrite;
    assign read_access  = setup_phase && !pwrite;

    // Register next values; sleep has no path here so contents survive wake
    always_comb begin
        next_ref_enable_source_ctrl = ref_enable_source_ctrl;
        next_ref_level_code         = ref_level_code;
        if (write_access && paddr == vrlc_pkg::ADDR_ENABLE_SOURCE_CTRL) begin
            next_ref_enable_source_ctrl = merge_write(ref_enable_source_ctrl, pwdata[7:0],
                vrlc_pkg::MASK_ENABLE_SOURCE_CTRL, pstrb[0]);
        end
        if (write_access && paddr == vrlc_pkg::ADDR_LEVEL_CODE) begin
            next_ref_level_code = merge_write(ref_level_code, pwdata[7:0],
                vrlc_pkg::MASK_LEVEL_CODE, pstrb[0]);
        end
    end

    // Reset clears enable, both pin routes and the level code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_enable_source_ctrl <= vrlc_pkg::RESET_ENABLE_SOURCE_CTRL;
            ref_level_code         <= vrlc_pkg::RESET_LEVEL_CODE;
        end else begin
            ref_enable_source_ctrl <= next_ref_enable_source_ctrl;
            ref_level_code         <= next_ref_level_code;
        end
    end

    // Bus answer: ready one cycle after setup; unmapped addresses report an error
    always_comb begin
        next_pready  = setup_phase;
        next_pslverr = setup_phase && !addr_hit;
        next_prdata  = '0;
        if (read_access) begin
            case (paddr)
                vrlc_pkg::ADDR_ENABLE_SOURCE_CTRL: begin
                    next_prdata = {24'h000000, ref_enable_source_ctrl};
                end
                vrlc_pkg::ADDR_LEVEL_CODE: begin
                    next_prdata = {24'h000000, ref_level_code};
                end
                vrlc_pkg::ADDR_PIN_SENSE: begin
                    next_prdata = {30'h0, pin2_read, pin1_read};
                end
                default: begin
                    next_prdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Ladder controls follow the registers one edge later, no shadow stage.
    // The analog ladder forms Vneg + (Vpos - Vneg) * code / 32 from these taps.
    always_comb begin
        next_ladder                = '0;
        next_ladder.ladder_power   = converter_enable;
        next_ladder.internal_route = converter_enable;
        if (converter_enable) begin
            next_ladder.tap_select = tap_decode(level_code);
        end
        case (positive_source_select)
            vrlc_pkg::POS_SOURCE_SUPPLY: begin
                next_ladder.pos_supply = 1'b1;
            end
            vrlc_pkg::POS_SOURCE_EXT_PIN: begin
                next_ladder.pos_ext_pin = 1'b1;
            end
            vrlc_pkg::POS_SOURCE_FIXED_REF: begin
                next_ladder.pos_fixed_ref = 1'b1;
            end
            default: begin
                // Reserved code leaves the top of the ladder floating-safe
                next_ladder.pos_supply = 1'b0;
            end
        endcase
        next_ladder.neg_ext_pin = negative_source_select;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ladder <= '0;
        end else begin
            ladder <= next_ladder;
        end
    end

    // Pad inputs come from outside; two flops before anything reads them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad1_sync <= 2'h0;
            pad2_sync <= 2'h0;
        end else begin
            pad1_sync <= {pad1_sync[0], ref_output_pin1};
            pad2_sync <= {pad2_sync[0], ref_output_pin2};
        end
    end

    // Pin routes follow their enable bits one edge later, through the override flops
    vrlc_pin_override u_pin1 (
        .pclk        (pclk),
        .presetn     (presetn),
        .route_en    (ref_pin1_output_enable),
        .pad_in_sync (pad1_sync[1]),
        .ovr         (pin1_ovr),
        .pin_read    (pin1_read)
    );

    vrlc_pin_override u_pin2 (
        .pclk        (pclk),
        .presetn     (presetn),
        .route_en    (ref_pin2_output_enable),
        .pad_in_sync (pad2_sync[1]),
        .ovr         (pin2_ovr),
        .pin_read    (pin2_read)
    );

    // Checks; the sampled reset masks the release edge, where $past sees pre-reset state
    property p_power_follows_enable;
        @(posedge pclk) disable iff (!presetn)
        presetn |-> ladder.ladder_power == $past(converter_enable);
    endproperty
    a_power_follows_enable: assert property (p_power_follows_enable)
        else $error("ladder power does not follow enable");

    property p_tap_onehot;
        @(posedge pclk) disable iff (!presetn)
        presetn && $past(converter_enable)
            |-> ladder.tap_select == tap_decode($past(level_code));
    endproperty
    a_tap_onehot: assert property (p_tap_onehot)
        else $error("tap select wrong for level code");

    property p_tap_off;
        @(posedge pclk) disable iff (!presetn)
        !converter_enable |=> ladder.tap_select == '0;
    endproperty
    a_tap_off: assert property (p_tap_off)
        else $error("tap select active while off");

    property p_pos_source;
        @(posedge pclk) disable iff (!presetn)
        positive_source_select == vrlc_pkg::POS_SOURCE_FIXED_REF
            |=> ladder.pos_fixed_ref && !ladder.pos_supply && !ladder.pos_ext_pin;
    endproperty
    a_pos_source: assert property (p_pos_source)
        else $error("positive source select wrong");

    property p_pos_supply;
        @(posedge pclk) disable iff (!presetn)
        positive_source_select == vrlc_pkg::POS_SOURCE_SUPPLY
            |=> ladder.pos_supply && !ladder.pos_ext_pin && !ladder.pos_fixed_ref;
    endproperty
    a_pos_supply: assert property (p_pos_supply)
        else $error("supply not selected as positive source");

    // Reserved code must close no switch, or two sources could short together
    property p_pos_reserved;
        @(posedge pclk) disable iff (!presetn)
        positive_source_select == vrlc_pkg::POS_SOURCE_RESERVED
            |=> !ladder.pos_supply && !ladder.pos_ext_pin && !ladder.pos_fixed_ref;
    endproperty
    a_pos_reserved: assert property (p_pos_reserved)
        else $error("reserved positive code closed a source switch");

    property p_neg_source;
        @(posedge pclk) disable iff (!presetn)
        presetn |-> ladder.neg_ext_pin == $past(negative_source_select);
    endproperty
    a_neg_source: assert property (p_neg_source)
        else $error("negative source select wrong");

    property p_pin1_route;
        @(posedge pclk) disable iff (!presetn)
        $rose(ref_pin1_output_enable) |=> pin1_ovr.analog_connect;
    endproperty
    a_pin1_route: assert property (p_pin1_route)
        else $error("pin 1 not routed");

    property p_pin1_hold;
        @(posedge pclk) disable iff (!presetn)
        ref_pin1_output_enable |=> pin1_ovr.analog_connect;
    endproperty
    a_pin1_hold: assert property (p_pin1_hold)
        else $error("pin 1 route dropped while enabled");

    property p_pin2_set;
        @(posedge pclk) disable iff (!presetn)
        ref_pin2_output_enable |=> pin2_ovr.analog_connect;
    endproperty
    a_pin2_set: assert property (p_pin2_set)
        else $error("pin 2 not routed while enabled");

    property p_pin2_route;
        @(posedge pclk) disable iff (!presetn)
        !ref_pin2_output_enable |=> !pin2_ovr.analog_connect;
    endproperty
    a_pin2_route: assert property (p_pin2_route)
        else $error("pin 2 not released");

    property p_sleep_keeps;
        @(posedge pclk) disable iff (!presetn)
        (sleep_mode && !write_access) |=> $stable(ref_enable_source_ctrl);
    endproperty
    a_sleep_keeps: assert property (p_sleep_keeps)
        else $error("first register changed in sleep");

    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        ref_enable_source_ctrl[6] == 1'b0 && ref_enable_source_ctrl[1] == 1'b0 &&
        ref_level_code[7:5] == 3'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("unused bit set");

    property p_write_to_ladder;
        @(posedge pclk) disable iff (!presetn)
        (write_access && paddr == vrlc_pkg::ADDR_ENABLE_SOURCE_CTRL && pstrb[0])
            |-> ##2 ladder.ladder_power == $past(pwdata[7], 2);
    endproperty
    a_write_to_ladder: assert property (p_write_to_ladder)
        else $error("write did not reach ladder in time");

    property p_internal_route;
        @(posedge pclk) disable iff (!presetn)
        ladder.internal_route == ladder.ladder_power;
    endproperty
    a_internal_route: assert property (p_internal_route)
        else $error("internal route mismatch");

    c_enable_write: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(ladder.ladder_power));
    c_pin1_routed: cover property (@(posedge pclk) disable iff (!presetn)
        pin1_ovr.analog_connect && ladder.ladder_power);
    c_full_code: cover property (@(posedge pclk) disable iff (!presetn)
        ladder.tap_select[vrlc_pkg::LEVEL_COUNT-1]);
    c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
        pready && pslverr);

endmodule : vrlc_top

// ===== verification/vrlc_ladder_model.sv
// Behavioural model of the resistor ladder and pads behind the block
`timescale 1ns/1ns
module vrlc_ladder_model #(
    parameter int SUPPLY_MV  = 3300, // Supply level
    parameter int EXT_POS_MV = 2500, // External positive reference pin
    parameter int FIXED_MV   = 2048, // Fixed reference level
    parameter int EXT_NEG_MV = 256   // External negative reference pin
) (
    input  vrlc_pkg::vrlc_ladder_type  ladder,      // Ladder controls
    input  vrlc_pkg::vrlc_pin_ovr_type pin1_ovr,    // Pad 1 overrides
    input  vrlc_pkg::vrlc_pin_ovr_type pin2_ovr,    // Pad 2 overrides
    input  logic [1:0]                 drive_level, // Board level on free pads
    output int                         vout_mv,     // Ladder tap voltage
    output int                         cmp_in_mv,   // Comparator and ADC input
    output logic                       pad1,        // Pad 1 level
    output logic                       pad2         // Pad 2 level
);
    int pos_mv;
    int neg_mv;
    int tap;

    // Ladder ends and tap; an open top leaves the ladder at its bottom level
    always_comb begin
        neg_mv = ladder.neg_ext_pin ? EXT_NEG_MV : 0;
        pos_mv = neg_mv;
        if (ladder.pos_supply) begin
            pos_mv = SUPPLY_MV;
        end else if (ladder.pos_ext_pin) begin
            pos_mv = EXT_POS_MV;
        end else if (ladder.pos_fixed_ref) begin
            pos_mv = FIXED_MV;
        end
        tap = 0;
        for (int i = 0; i < 32; i++) begin
            if (ladder.tap_select[i]) begin
                tap = i;
            end
        end
        vout_mv = ladder.ladder_power ? neg_mv + (pos_mv - neg_mv) * tap / 32 : 0;
        cmp_in_mv = ladder.internal_route ? vout_mv : 0;
    end

    // A routed pad carries an analog level; show it high so a stray read is caught
    assign pad1 = pin1_ovr.analog_connect ? 1'b1 : drive_level[0];
    assign pad2 = pin2_ovr.analog_connect ? 1'b1 : drive_level[1];
endmodule : vrlc_ladder_model

// ===== verification/voltage_ref_level_control_test.sv
// Testbench: APB register access, ladder selects, pin overrides and reset
`timescale 1ns/1ns
module voltage_ref_level_control_test;
    localparam int EXT_POS_MV = 2500;
    localparam int EXT_NEG_MV = 256;
    localparam logic [11:0] CTRL = vrlc_pkg::ADDR_ENABLE_SOURCE_CTRL;
    localparam logic [11:0] LVL  = vrlc_pkg::ADDR_LEVEL_CODE;
    localparam logic [11:0] SNS  = vrlc_pkg::ADDR_PIN_SENSE;
    logic                       pclk, presetn, psel, penable, pwrite, sleep_mode;
    logic                       pready, pslverr, pad1, pad2, rerr;
    logic [11:0]                paddr;
    logic [31:0]                pwdata, prdata, rdata;
    logic [3:0]                 pstrb;
    logic [2:0]                 exp_pos;
    logic [1:0]                 drive_level;
    vrlc_pkg::vrlc_ladder_type  ladder;
    vrlc_pkg::vrlc_pin_ovr_type pin1_ovr, pin2_ovr;
    int                         vout_mv, cmp_in_mv, err_count, n_compared;

    vrlc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .sleep_mode(sleep_mode), .ref_output_pin1(pad1), .ref_output_pin2(pad2),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ladder(ladder),
        .pin1_ovr(pin1_ovr), .pin2_ovr(pin2_ovr));

    vrlc_ladder_model #(.EXT_POS_MV(EXT_POS_MV), .EXT_NEG_MV(EXT_NEG_MV)) u_ladder (
        .ladder(ladder), .pin1_ovr(pin1_ovr), .pin2_ovr(pin2_ovr),
        .drive_level(drive_level), .vout_mv(vout_mv), .cmp_in_mv(cmp_in_mv),
        .pad1(pad1), .pad2(pad2));

    // 250 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic finish_test;
        if (err_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    // One APB transfer; an idle cycle before setup keeps drivers from double assigns
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_count++;
            finish_test();
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(nm, rdata, e);
    endtask : rd_chk

    // Controls follow a write one edge after it commits
    task automatic wait_out;
        @(posedge pclk);
        @(negedge pclk);
    endtask : wait_out

    // Hang guard
    initial begin
        #200000;
        err_count++;
        finish_test();
    end

    initial begin
        {presetn, psel, penable, pwrite, sleep_mode} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        drive_level = 2'h3;
        err_count = 0;
        n_compared = 0;
        repeat (6) @(posedge pclk);
        check("ladder in reset", ladder, 40'h0);
        presetn <= 1'b1;
        wait_out();
        check("ladder after reset", ladder, {1'b0, 32'h0, 5'b10000});
        rd_chk("ctrl reset", CTRL, 32'h0);
        rd_chk("level reset", LVL, 32'h0);
        apb(1'b1, CTRL, 32'hFFFF_FF42);
        rd_chk("ctrl unused bits", CTRL, 32'h0);
        apb(1'b1, LVL, 32'hFFFF_FFFF);
        rd_chk("level unused bits", LVL, 32'h1F);
        apb(1'b1, CTRL, 32'hFF);
        rd_chk("ctrl used bits", CTRL, 32'hBD);
        pstrb <= 4'h0;
        apb(1'b1, CTRL, 32'h0);
        pstrb <= 4'hF;
        rd_chk("ctrl strobe off", CTRL, 32'hBD);
        // Every positive source code with both negative sources
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, CTRL, {24'h0, 1'b1, 3'h0, s[2:1], 1'b0, s[0]});
            wait_out();
            exp_pos = (s[2:1] == 2'h0) ? 3'b100 : (s[2:1] == 2'h1) ? 3'b010 :
                      (s[2:1] == 2'h2) ? 3'b001 : 3'b000;
            check("pos source", {ladder.pos_supply, ladder.pos_ext_pin,
                  ladder.pos_fixed_ref}, exp_pos);
            check("neg source", ladder.neg_ext_pin, s[0]);
            check("power", {ladder.ladder_power, ladder.internal_route}, 2'b11);
        end
        // Every level code against the ratiometric output
        apb(1'b1, CTRL, 32'h85);
        for (int k = 0; k < 32; k++) begin
            apb(1'b1, LVL, k);
            wait_out();
            check("tap", ladder.tap_select, 32'h1 << k);
            check("vout", vout_mv, EXT_NEG_MV + (EXT_POS_MV - EXT_NEG_MV) * k / 32);
            check("internal route", cmp_in_mv, vout_mv);
        end
        apb(1'b1, CTRL, 32'h05);
        wait_out();
        check("disabled", {ladder.ladder_power, ladder.tap_select}, 33'h0);
        // Route each pad in turn; routed pad reads zero though it sits high
        apb(1'b1, CTRL, 32'h20);
        wait_out();
        check("pin1 routed", pin1_ovr, 4'hF);
        check("pin2 free", pin2_ovr, 4'h0);
        repeat (5) @(posedge pclk);
        rd_chk("sense pin1 routed", SNS, 32'h2);
        apb(1'b1, CTRL, 32'h10);
        wait_out();
        check("pin2 routed", pin2_ovr, 4'hF);
        check("pin1 free", pin1_ovr, 4'h0);
        repeat (5) @(posedge pclk);
        rd_chk("sense pin2 routed", SNS, 32'h1);
        drive_level <= 2'h2;
        repeat (5) @(posedge pclk);
        rd_chk("sense pin1 low", SNS, 32'h0);
        // Sleep leaves settings and converter running
        apb(1'b1, CTRL, 32'hB9);
        sleep_mode <= 1'b1;
        repeat (10) @(posedge pclk);
        rd_chk("ctrl in sleep", CTRL, 32'hB9);
        check("power in sleep", ladder.ladder_power, 1'b1);
        sleep_mode <= 1'b0;
        apb(1'b1, 12'h00C, 32'hFF);
        check("unmapped error", rerr, 1'b1);
        rd_chk("unmapped read", 12'h00C, 32'h0);
        // Reset in mid-run
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        check("outputs in reset", {ladder, pin1_ovr, pin2_ovr}, 46'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("ctrl after reset", CTRL, 32'h0);
        rd_chk("level after reset", LVL, 32'h0);
        finish_test();
    end
endmodule : voltage_ref_level_control_test
